// ---- flow_ctrl_pkg.sv ----
package flow_ctrl_pkg;
    // register map of the device
    localparam logic [8:0] core_control_reg_off = 9'h101;
    localparam logic [8:0] core_status_reg_off = 9'h105;
    localparam logic [8:0] first_core_entry_point_off = 9'h10a;
    localparam logic [8:0] second_core_entry_point_off = 9'h10b;
    localparam logic [8:0] diag_routine_address_off = 9'h10c;
    localparam logic [8:0] lowside_diag_combination_off = 9'h141;
    localparam logic [8:0] highside_diag_combination_off = 9'h154;
    localparam logic [8:0] diag_error_reg_off = 9'h162;
    localparam logic [8:0] output_access_grant_off = 9'h184;
    localparam logic [8:0] driver_configuration_off = 9'h1c5;
    localparam logic [8:0] clear_on_read_select_off = 9'h1ce;
    localparam logic [8:0] driver_disable_status_off = 9'h1d2;
    localparam int return_select_bit = 0;
    localparam logic [15:0] reg_reset_value = 16'h0000;
    localparam logic [9:0] pc_reset_value = 10'h000;
    localparam int pc_width = 10;
    localparam int rel_width = 6;

    // instruction operations presented by the decoder
    typedef enum logic [4:0] {
        op_none, op_reset_regs, op_set_ctrl_bit, op_set_status_bit,
        op_alu_config, op_mailbox_select, op_irq_config, op_spi_addr,
        op_spi_write, op_spi_read, op_pin_drive, op_diag_one,
        op_diag_all, op_diag_shortcut, op_call, op_return_sub,
        op_soft_irq, op_irq_return, op_jump_rel, op_jump_far,
        op_load_far_a, op_load_far_b
    } op_type;

    typedef enum logic [1:0] {
        ret_resume, ret_entry, ret_ignore
    } ret_mode_type;

    // reset selector: one register or a whole group
    typedef enum logic [2:0] {
        rst_ctrl, rst_status, rst_diag_err, rst_ctrl_status, rst_all
    } rst_sel_type;
endpackage

// ---- microcore_flow_control.sv ----
`timescale 1ns/1ps
// How it works
// RULE_01 - reset instruction clears control, status, diagnosis registers
// RULE_02 - single-bit set of control or status
// RULE_03 - one-cycle alu saturation mode configuration
// RULE_04 - select which core mailbox transfers address
// RULE_05 - interrupt config picks automatic return behaviour
// RULE_06 - return on re-enable or status cleared
// RULE_07 - software sets clear-on-read for status return
// RULE_08 - backdoor spi access blocked by register lock
// RULE_09 - backdoor transfers use value register, two cycles
// RULE_10 - instruction directly drives host interrupt pin
// RULE_11 - diagnosis interrupt from configured feedback combination
// RULE_12 - diagnosis enable one, all, shortcut; granted outputs
// RULE_13 - diagnosis interrupt starts at routine address
// RULE_14 - call saves pc in link register, one level
// RULE_15 - subroutine return restores pc from link
// RULE_16 - three prioritised sources; software via request
// RULE_17 - interrupt saves pc; others queued or cleared
// RULE_18 - interrupt return reloads saved or entry address
// RULE_19 - resumed conditional restores captured feedback status
// RULE_20 - relative jump with six-bit offset, one cycle
// RULE_21 - far jump from selected register, nondestructive
// RULE_22 - far register load honoured by next jump
// RULE_23 - queued interrupts served highest priority first
module microcore_flow_control
    import flow_ctrl_pkg::*;
#(
    parameter int channels = 8,
    parameter int core_index = 0
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // decoded instruction
    input wire logic instr_valid_in,
    input wire op_type op_in,
    input wire logic [15:0] operand_in,
    input wire logic cond_true_in,
    input wire logic [15:0] data_in,
    // device state
    input wire logic [channels-1:0] hs_vds_in,
    input wire logic [channels-1:0] hs_src_in,
    input wire logic [channels-1:0] cmd_in,
    input wire logic [channels-1:0] ls_vds_in,
    input wire logic [channels-1:0] output_access_grant_in,
    input wire logic [15:0] highside_diag_combination_in,
    input wire logic [15:0] lowside_diag_combination_in,
    input wire logic [15:0] driver_configuration_in,
    input wire logic [15:0] driver_disable_status_in,
    input wire logic [15:0] first_core_entry_point_in,
    input wire logic [15:0] second_core_entry_point_in,
    input wire logic [15:0] diag_routine_address_in,
    input wire logic drivers_enabled_in,
    input wire logic [3:0] feedback_in,
    // spi backdoor
    input wire logic spi_lock_in,
    input wire logic [15:0] spi_rdata_in,
    output logic spi_we_out,
    output logic spi_re_out,
    output logic [8:0] spi_addr_out,
    output logic [15:0] spi_wdata_out,
    // state
    output logic [pc_width-1:0] program_counter_out,
    output logic [15:0] core_control_reg_out,
    output logic [15:0] core_status_reg_out,
    output logic [channels-1:0] diag_error_reg_out,
    output logic [channels-1:0] diag_enable_out,
    output logic [1:0] alu_saturation_out,
    output logic [1:0] inter_core_mailbox_out,
    output logic host_interrupt_pin_out,
    output logic in_interrupt_out,
    output logic [3:0] feedback_view_out,
    output logic stall_out
);
    logic [pc_width-1:0] pc_q, pc_d, link_q, link_d, iret_q, iret_d;
    logic [pc_width-1:0] far_a_q, far_a_d, far_b_q, far_b_d;
    logic [15:0] ctrl_q, ctrl_d, stat_q, stat_d, spi_val_q, spi_val_d;
    logic [channels-1:0] err_q, err_d, den_q, den_d, sc_q, sc_d;
    logic [8:0] spi_add_q, spi_add_d;
    logic [1:0] sat_q, sat_d, mbx_q, mbx_d;
    ret_mode_type rmode_q, rmode_d;
    logic pin_q, pin_d, inirq_q, inirq_d, sub_q, sub_d;
    logic [2:0] pend_q, pend_d;
    logic [3:0] fb_q, fb_d;
    logic spi_busy_q, spi_busy_d, spi_rd_q, spi_rd_d, spi_blk_q, spi_blk_d;
    logic dis_q, dstat_nz_q;
    logic [channels-1:0] diag_hit;
    logic auto_ret, go;
    logic [pc_width-1:0] entry, next_pc;

    function automatic logic [pc_width-1:0] addr10(input logic [15:0] v);
        return v[pc_width-1:0];
    endfunction

    // diagnosis match per channel, high-side from highside combination bits 3:0, low-side from lowside bits 2:0
    always_comb begin
        for (int i = 0; i < channels; i++) begin
            diag_hit[i] = den_q[i] & output_access_grant_in[i] & ( // [RULE_12]
                (hs_vds_in[i] == highside_diag_combination_in[0] &&
                 hs_src_in[i] == highside_diag_combination_in[1] &&
                 cmd_in[i] == highside_diag_combination_in[2] &&
                 highside_diag_combination_in[3]) ||
                (ls_vds_in[i] == lowside_diag_combination_in[0] &&
                 cmd_in[i] == lowside_diag_combination_in[1] &&
                 lowside_diag_combination_in[2])); // [RULE_11]
        end
    end

    // automatic return; status-clear mode relies on clear-on-read [RULE_07]
    always_comb begin
        if (driver_configuration_in[return_select_bit]) begin
            auto_ret = dstat_nz_q && driver_disable_status_in == 16'h0000;
        end else begin
            auto_ret = dis_q && drivers_enabled_in; // [RULE_06]
        end
    end

    assign entry = (core_index == 0) ? addr10(first_core_entry_point_in)
                                     : addr10(second_core_entry_point_in);
    assign go = instr_valid_in && !spi_busy_q;
    assign next_pc = pc_q + 10'h001;

    always_comb begin
        pc_d = pc_q;
        link_d = link_q;
        iret_d = iret_q;
        far_a_d = far_a_q;
        far_b_d = far_b_q;
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        err_d = err_q | diag_hit;
        den_d = den_q;
        sc_d = sc_q;
        spi_add_d = spi_add_q;
        spi_val_d = spi_val_q;
        sat_d = sat_q;
        mbx_d = mbx_q;
        rmode_d = rmode_q;
        pin_d = pin_q;
        inirq_d = inirq_q;
        sub_d = sub_q;
        pend_d = pend_q;
        fb_d = fb_q;
        spi_busy_d = 1'b0;
        spi_rd_d = 1'b0;
        spi_blk_d = 1'b0;
        // sources latch into the queue; a same-cycle clear of the disable source beats its set [RULE_16]
        if (|diag_hit) begin
            pend_d[2] = 1'b1;
        end
        if (!drivers_enabled_in && !dis_q) begin
            pend_d[1] = 1'b1;
        end
        // second spi cycle completes the backdoor access [RULE_09]
        if (spi_busy_q && spi_rd_q && !spi_blk_q) begin
            spi_val_d = spi_rdata_in;
        end
        if (spi_busy_q) begin
            pc_d = next_pc;
        end
        if (go) begin
            pc_d = next_pc;
            case (op_in)
                op_reset_regs: begin
                    case (rst_sel_type'(operand_in[2:0])) // [RULE_01]
                        rst_ctrl: ctrl_d = reg_reset_value;
                        rst_status: stat_d = reg_reset_value;
                        rst_diag_err: err_d = diag_hit;
                        rst_ctrl_status: begin
                            ctrl_d = reg_reset_value;
                            stat_d = reg_reset_value;
                        end
                        rst_all: begin
                            ctrl_d = reg_reset_value;
                            stat_d = reg_reset_value;
                            err_d = diag_hit;
                        end
                        default: ;
                    endcase
                end
                op_set_ctrl_bit: ctrl_d[operand_in[3:0]] = operand_in[4];
                op_set_status_bit: stat_d[operand_in[3:0]] = operand_in[4];
                op_alu_config: sat_d = operand_in[1:0]; // [RULE_03]
                op_mailbox_select: mbx_d = operand_in[1:0]; // [RULE_04]
                op_irq_config: begin
                    rmode_d = ret_mode_type'(operand_in[1:0]); // [RULE_05]
                    if (operand_in[1:0] == 2'b11) begin
                        rmode_d = ret_ignore;
                    end
                end
                op_spi_addr: spi_add_d = operand_in[8:0]; // [RULE_08]
                op_spi_write, op_spi_read: begin
                    pc_d = pc_q; // [RULE_09]
                    spi_busy_d = 1'b1;
                    spi_rd_d = (op_in == op_spi_read);
                    spi_blk_d = spi_lock_in; // [RULE_08]
                end
                op_pin_drive: pin_d = operand_in[0]; // [RULE_10]
                op_diag_one: den_d[operand_in[2:0]] = operand_in[3];
                op_diag_all: den_d = {channels{operand_in[0]}}; // [RULE_12]
                op_diag_shortcut: begin
                    sc_d = operand_in[channels-1:0];
                    den_d = sc_d; // [RULE_12]
                end
                op_call: begin
                    if (!sub_q && cond_true_in) begin
                        link_d = next_pc; // [RULE_14]
                        sub_d = 1'b1;
                        pc_d = addr10(operand_in);
                    end
                end
                op_return_sub: begin
                    pc_d = link_q; // [RULE_15]
                    sub_d = 1'b0;
                end
                op_soft_irq: pend_d[0] = 1'b1; // [RULE_16]
                op_irq_return: begin
                    inirq_d = 1'b0;
                    pc_d = operand_in[0] ? entry : iret_q; // [RULE_18]
                    if (operand_in[1]) begin
                        pend_d = {|diag_hit, 1'b0, 1'b0}; // [RULE_17]
                    end
                end
                op_jump_rel: begin
                    if (cond_true_in) begin // [RULE_20]
                        pc_d = pc_q + {{(pc_width-rel_width){operand_in[5]}},
                                       operand_in[rel_width-1:0]};
                    end
                end
                op_jump_far: begin
                    if (cond_true_in) begin // [RULE_21]
                        pc_d = operand_in[0] ? far_b_q : far_a_q;
                    end
                end
                op_load_far_a: far_a_d = addr10(data_in); // [RULE_22]
                op_load_far_b: far_b_d = addr10(data_in);
                default: ;
            endcase
            // a load in this cycle reaches the far jump in the next [RULE_22]
        end
        // automatic return while in interrupt
        if (inirq_q && auto_ret && rmode_q != ret_ignore) begin
            inirq_d = 1'b0;
            pc_d = (rmode_q == ret_entry) ? entry : iret_q; // [RULE_05]
        end
        // take one interrupt at a time, highest first [RULE_23]
        if (!inirq_q && !spi_busy_q && |pend_q) begin
            inirq_d = 1'b1;
            iret_d = pc_q; // [RULE_17]
            fb_d = feedback_in; // [RULE_19]
            if (pend_q[2]) begin
                pc_d = addr10(diag_routine_address_in); // [RULE_13]
                pend_d[2] = |diag_hit;
            end else if (pend_q[1]) begin
                pc_d = addr10(diag_routine_address_in);
                pend_d[1] = 1'b0;
            end else begin
                pc_d = entry;
                pend_d[0] = 1'b0;
            end
        end
        // interrupted conditional resumes from captured feedback [RULE_19]
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pc_q <= pc_reset_value;
            link_q <= pc_reset_value;
            iret_q <= pc_reset_value;
            far_a_q <= pc_reset_value;
            far_b_q <= pc_reset_value;
            ctrl_q <= reg_reset_value;
            stat_q <= reg_reset_value;
            spi_val_q <= reg_reset_value;
            err_q <= '0;
            den_q <= '0;
            sc_q <= '0;
            spi_add_q <= 9'h000;
            sat_q <= 2'h0;
            mbx_q <= 2'h0;
            rmode_q <= ret_resume;
            pin_q <= 1'b1;
            inirq_q <= 1'b0;
            sub_q <= 1'b0;
            pend_q <= 3'h0;
            fb_q <= 4'h0;
            spi_busy_q <= 1'b0;
            spi_rd_q <= 1'b0;
            spi_blk_q <= 1'b0;
            dis_q <= 1'b0;
            dstat_nz_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            link_q <= link_d;
            iret_q <= iret_d;
            far_a_q <= far_a_d;
            far_b_q <= far_b_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            spi_val_q <= spi_val_d;
            err_q <= err_d;
            den_q <= den_d;
            sc_q <= sc_d;
            spi_add_q <= spi_add_d;
            sat_q <= sat_d;
            mbx_q <= mbx_d;
            rmode_q <= rmode_d;
            pin_q <= pin_d;
            inirq_q <= inirq_d;
            sub_q <= sub_d;
            pend_q <= pend_d;
            fb_q <= fb_d;
            spi_busy_q <= spi_busy_d;
            spi_rd_q <= spi_rd_d;
            spi_blk_q <= spi_blk_d;
            dis_q <= !drivers_enabled_in;
            dstat_nz_q <= driver_disable_status_in != 16'h0000;
        end
    end

    // strobes land in the second cycle, suppressed when locked [RULE_08]
    assign spi_we_out = spi_busy_q && !spi_rd_q && !spi_blk_q;
    assign spi_re_out = spi_busy_q && spi_rd_q && !spi_blk_q;
    assign spi_addr_out = spi_add_q;
    assign spi_wdata_out = spi_val_q;
    assign program_counter_out = pc_q;
    assign core_control_reg_out = ctrl_q;
    assign core_status_reg_out = stat_q;
    assign diag_error_reg_out = err_q;
    assign diag_enable_out = den_q;
    assign alu_saturation_out = sat_q;
    assign inter_core_mailbox_out = mbx_q;
    assign host_interrupt_pin_out = pin_q;
    assign in_interrupt_out = inirq_q;
    assign feedback_view_out = fb_q;
    assign stall_out = spi_busy_q;
endmodule

// ---- microcore_flow_control_asserts.sv ----
`timescale 1ns/1ps
module microcore_flow_control_asserts
    import flow_ctrl_pkg::*;
(
    // watched ports
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire op_type op_in,
    input wire logic [15:0] operand_in,
    input wire logic cond_true_in,
    input wire logic spi_lock_in,
    input wire logic [15:0] spi_rdata_in,
    input wire logic spi_we_out,
    input wire logic spi_re_out,
    input wire logic [15:0] spi_wdata_out,
    input wire logic [pc_width-1:0] program_counter_out,
    input wire logic [15:0] core_control_reg_out,
    input wire logic [15:0] core_status_reg_out,
    input wire logic [1:0] alu_saturation_out,
    input wire logic [1:0] inter_core_mailbox_out,
    input wire logic host_interrupt_pin_out,
    input wire logic in_interrupt_out,
    input wire logic stall_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic tk;
    assign tk = instr_valid_in && !stall_out;
    AST_STALL_ONE: assert property (stall_out |=> !stall_out)
        else $error("stall longer than one cycle");
    AST_STROBE: assert property ((spi_re_out || spi_we_out) |-> stall_out)
        else $error("spi strobe outside second cycle");
    AST_READ: assert property (tk && op_in == op_spi_read && !spi_lock_in
        |=> spi_re_out ##1 spi_wdata_out == $past(spi_rdata_in))
        else $error("backdoor read value lost");
    AST_LOCK: assert property (tk && spi_lock_in &&
        (op_in == op_spi_read || op_in == op_spi_write)
        |=> !spi_re_out && !spi_we_out)
        else $error("locked target strobed");
    AST_REL: assert property (tk && op_in == op_jump_rel && cond_true_in
        |=> program_counter_out == $past(program_counter_out) +
        {{4{$past(operand_in[5])}}, $past(operand_in[5:0])})
        else $error("relative jump target wrong");
    AST_FALL: assert property (tk && !cond_true_in &&
        (op_in == op_jump_rel || op_in == op_jump_far)
        |=> program_counter_out == $past(program_counter_out) + 10'h001)
        else $error("untaken jump did not fall through");
    AST_PIN: assert property (tk && op_in == op_pin_drive
        |=> host_interrupt_pin_out == $past(operand_in[0]))
        else $error("pin drive ignored");
    AST_MBOX: assert property (tk && op_in == op_mailbox_select
        |=> inter_core_mailbox_out == $past(operand_in[1:0]))
        else $error("mailbox select wrong");
    AST_ALU: assert property (tk && op_in == op_alu_config
        |=> alu_saturation_out == $past(operand_in[1:0]))
        else $error("saturation mode wrong");
    AST_SETBIT: assert property (tk && op_in == op_set_ctrl_bit
        |=> core_control_reg_out[$past(operand_in[3:0])] == $past(operand_in[4]))
        else $error("control bit not set");
    AST_RSTALL: assert property (tk && op_in == op_reset_regs &&
        operand_in[2:0] == 3'h4
        |=> core_control_reg_out == 16'h0000 && core_status_reg_out == 16'h0000)
        else $error("group reset incomplete");
    cover property (tk && op_in == op_spi_read);
    cover property ($rose(in_interrupt_out));
    cover property (tk && op_in == op_jump_far && cond_true_in);
endmodule
bind microcore_flow_control microcore_flow_control_asserts chk_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .op_in(op_in),
    .operand_in(operand_in), .cond_true_in(cond_true_in),
    .spi_lock_in(spi_lock_in), .spi_rdata_in(spi_rdata_in),
    .spi_we_out(spi_we_out), .spi_re_out(spi_re_out),
    .spi_wdata_out(spi_wdata_out),
    .program_counter_out(program_counter_out),
    .core_control_reg_out(core_control_reg_out),
    .core_status_reg_out(core_status_reg_out),
    .alu_saturation_out(alu_saturation_out),
    .inter_core_mailbox_out(inter_core_mailbox_out),
    .host_interrupt_pin_out(host_interrupt_pin_out),
    .in_interrupt_out(in_interrupt_out), .stall_out(stall_out));

// ---- spi_regfile_model.sv ----
`timescale 1ns/1ps
module spi_regfile_model
    import flow_ctrl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic spi_we_in,
    input wire logic spi_re_in,
    input wire logic [8:0] spi_addr_in,
    input wire logic [15:0] spi_wdata_in,
    output logic [15:0] spi_rdata_out,
    output logic spi_lock_out
);
    logic [15:0] mem_q [0:511];
    logic [15:0] last_q;
    initial begin
        foreach (mem_q[i]) mem_q[i] = 16'ha5c3 ^ 16'(i);
        last_q = 16'h0000;
    end
    // one locked target, so refusals are visible
    assign spi_lock_out = (spi_addr_in == driver_disable_status_off);
    // idle bus shows inverse of last value, stale data cannot pass
    assign spi_rdata_out = spi_re_in ? mem_q[spi_addr_in] : ~last_q;
    always @(posedge clk_sys_in) begin
        if (spi_re_in) last_q <= mem_q[spi_addr_in];
        if (spi_we_in && !spi_lock_out) mem_q[spi_addr_in] <= spi_wdata_in;
    end
endmodule

// ---- test_microcore_flow_control.sv ----
`timescale 1ns/1ps
module test_microcore_flow_control;
    import flow_ctrl_pkg::*;
    logic clk_sys_in, rst_in, instr_valid_in, cond_true_in, spi_lock_in;
    op_type op_in;
    logic [15:0] operand_in, data_in, spi_rdata_in, v;
    logic [7:0] fb, grant;
    logic [9:0] p;
    int fails, num_checks;
    wire spi_we_out, spi_re_out, stall_out, pin, in_int;
    wire [8:0] spi_addr_out;
    wire [15:0] spi_wdata_out, ctrl, stat;
    wire [9:0] pc;
    wire [7:0] derr, den;
    wire [1:0] alu, mbox;
    wire [3:0] fview;
    microcore_flow_control microcore_flow_control_i (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .instr_valid_in(instr_valid_in), .op_in(op_in),
        .operand_in(operand_in), .cond_true_in(cond_true_in),
        .data_in(data_in), .hs_vds_in(fb), .hs_src_in(fb), .cmd_in(fb),
        .ls_vds_in(fb), .output_access_grant_in(grant),
        .highside_diag_combination_in(16'(fb)),
        .lowside_diag_combination_in(16'(fb)),
        .driver_configuration_in(16'(fb)),
        .driver_disable_status_in(16'(fb)),
        .first_core_entry_point_in(16'h0200),
        .second_core_entry_point_in(16'h0280),
        .diag_routine_address_in(16'h0300), .drivers_enabled_in(1'b1),
        .feedback_in(fb[3:0]), .spi_lock_in(spi_lock_in),
        .spi_rdata_in(spi_rdata_in), .spi_we_out(spi_we_out),
        .spi_re_out(spi_re_out), .spi_addr_out(spi_addr_out),
        .spi_wdata_out(spi_wdata_out), .program_counter_out(pc),
        .core_control_reg_out(ctrl), .core_status_reg_out(stat),
        .diag_error_reg_out(derr), .diag_enable_out(den),
        .alu_saturation_out(alu), .inter_core_mailbox_out(mbox),
        .host_interrupt_pin_out(pin), .in_interrupt_out(in_int),
        .feedback_view_out(fview), .stall_out(stall_out));
    spi_regfile_model spi_regfile_model_i (
        .clk_sys_in(clk_sys_in), .spi_we_in(spi_we_out),
        .spi_re_in(spi_re_out), .spi_addr_in(spi_addr_out),
        .spi_wdata_in(spi_wdata_out), .spi_rdata_out(spi_rdata_in),
        .spi_lock_out(spi_lock_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string n, input logic [15:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic op(input op_type o, input logic [15:0] a, input logic c);
        @(negedge clk_sys_in);
        instr_valid_in = 1'b1;
        op_in = o;
        operand_in = a;
        cond_true_in = c;
    endtask
    task automatic idle();
        @(negedge clk_sys_in);
        instr_valid_in = 1'b0;
    endtask
    task automatic wait_irq();
        for (int k = 0; k < 8 && in_int !== 1'b1; k++) idle();
        chk("in_int", 16'(in_int), 16'h0001);
    endtask
    task automatic wrap_up();
        if (fails == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        wrap_up();
    end
    initial begin
        rst_in = 1'b1;
        instr_valid_in = 1'b0;
        op_in = op_none;
        operand_in = 16'h0000;
        cond_true_in = 1'b0;
        data_in = 16'h0000;
        fb = 8'h00;
        grant = 8'h0f;
        repeat (3) @(negedge clk_sys_in);
        rst_in = 1'b0;
        chk("pin", 16'(pin), 16'h0001);
        op(op_set_ctrl_bit, 16'h0013, 1'b0);
        op(op_set_status_bit, 16'h0015, 1'b0);
        idle();
        chk("ctrl", ctrl, 16'h0008);
        chk("stat", stat, 16'h0020);
        op(op_reset_regs, 16'h0000, 1'b0);
        idle();
        chk("ctrl", ctrl, 16'h0000);
        chk("stat", stat, 16'h0020);
        op(op_reset_regs, 16'h0004, 1'b0);
        idle();
        chk("stat", stat, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            op(op_alu_config, 16'(k), 1'b0);
            op(op_mailbox_select, 16'(3 - k), 1'b0);
            op(op_pin_drive, 16'(k), 1'b0);
            idle();
            chk("alu", 16'(alu), 16'(k));
            chk("mbox", 16'(mbox), 16'(3 - k));
            chk("pin", 16'(pin), 16'(k & 1));
        end
        p = pc;
        op(op_jump_rel, 16'h003e, 1'b1);
        idle();
        chk("pc", 16'(pc), 16'(p - 10'h002));
        p = pc;
        op(op_jump_rel, 16'h0005, 1'b0);
        idle();
        chk("pc", 16'(pc), 16'(p + 10'h001));
        data_in = 16'h0155;
        op(op_load_far_a, 16'h0000, 1'b0);
        op(op_jump_far, 16'h0000, 1'b1);
        idle();
        chk("pc", 16'(pc), 16'h0155);
        data_in = 16'h00aa;
        op(op_load_far_b, 16'h0000, 1'b0);
        op(op_jump_far, 16'h0001, 1'b1);
        op(op_jump_far, 16'h0000, 1'b1);
        idle();
        chk("pc", 16'(pc), 16'h0155);
        p = pc;
        op(op_call, 16'h0080, 1'b1);
        idle();
        chk("pc", 16'(pc), 16'h0080);
        op(op_return_sub, 16'h0000, 1'b0);
        idle();
        chk("pc", 16'(pc), 16'(p + 10'h001));
        op(op_spi_addr, 16'h0141, 1'b0);
        op(op_spi_read, 16'h0000, 1'b0);
        idle();
        idle();
        v = 16'ha5c3 ^ 16'h0141;
        chk("spi_addr", 16'(spi_addr_out), 16'h0141);
        chk("spi_val", spi_wdata_out, v);
        op(op_spi_addr, 16'h01d2, 1'b0);
        op(op_spi_read, 16'h0000, 1'b0);
        idle();
        idle();
        chk("spi_val", spi_wdata_out, v);
        op(op_spi_addr, 16'h0154, 1'b0);
        op(op_spi_write, 16'h0000, 1'b0);
        idle();
        idle();
        chk("mem", spi_regfile_model_i.mem_q[9'h154], v);
        op(op_diag_all, 16'h0001, 1'b0);
        idle();
        chk("diag_en", 16'(den), 16'h00ff);
        op(op_soft_irq, 16'h0000, 1'b0);
        idle();
        wait_irq();
        chk("pc", 16'(pc), 16'h0200);
        op(op_irq_return, 16'h0001, 1'b0);
        idle();
        chk("in_int", 16'(in_int), 16'h0000);
        chk("pc", 16'(pc), 16'h0200);
        // status-clear return mode, status held nonzero
        fb = 8'h0f;
        wait_irq();
        chk("pc", 16'(pc), 16'h0300);
        chk("derr", 16'(derr), 16'h000f);
        chk("fview", 16'(fview), 16'h000f);
        fb = 8'h00;
        op(op_irq_return, 16'h0002, 1'b0);
        idle();
        idle();
        chk("in_int", 16'(in_int), 16'h0000);
        chk("pc", 16'(pc), 16'h0200);
        op(op_reset_regs, 16'h0002, 1'b0);
        idle();
        chk("derr", 16'(derr), 16'h0000);
        wrap_up();
    end
endmodule
